/* File: pkg/pol_pkg.sv */
// package: register offsets, widths and reset values of the port output latches
`default_nettype none
package pol_pkg;
    localparam int          PORT_W      = 8;
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  OFF_PORT_A  = 4'h0;
    localparam logic [3:0]  OFF_PORT_B  = 4'h1;
    localparam logic [7:0]  LATCH_RESET = 8'hFF;
    typedef enum logic [1:0] {
        POL_PIN_INPUT,
        POL_PIN_OUTPUT
    } pol_dir_t;
endpackage
`default_nettype wire

/* File: pkg/pol_pin_if.sv */
// interface: latch value and direction toward one port's pin driver
`default_nettype none
interface pol_pin_if #(parameter int W = 8);
    logic [W-1:0] latch;
    logic [W-1:0] dir_out;
    logic [W-1:0] pin_do;
    logic [W-1:0] pin_oe;
    logic [W-1:0] pullup_en;
    modport ctrl (output latch, output dir_out, input pin_do, input pin_oe, input pullup_en);
    modport drv  (input latch, input dir_out, output pin_do, output pin_oe, output pullup_en);
endinterface
`default_nettype wire

/* File: core/pol_pin_drv.sv */
// module: per-pin steering of a latch bit to drive data or weak pull-up enable
`default_nettype none
module pol_pin_drv #(
    parameter int W = 8
) (
    pol_pin_if.drv p
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // output pin: latch bit is the drive level
            assign p.pin_do[g]    = p.latch[g];
            assign p.pin_oe[g]    = p.dir_out[g];
            // input pin: latch bit switches the weak pull-up
            assign p.pullup_en[g] = ~p.dir_out[g] & p.latch[g];
        end
    endgenerate
endmodule
`default_nettype wire

/* File: core/pol_port_latches.sv */
// module: output latches of two 8-bit general-purpose ports on the core's register space
`default_nettype none
// How it works
// - every reset loads both port output latches with all ones.
// - an output pin is driven with its latch bit.
// - an input pin uses its latch bit to enable its weak pull-up.
// - a core write replaces the latch contents, nothing else happens.
// - a core read returns the latch contents, never the pin levels.
// - changing pin direction leaves the latch contents untouched.
// - port a pin levels are synchronised for external-interrupt logic outside this module; port b is plain bidirectional.
module pol_port_latches #(
    parameter int W = pol_pkg::PORT_W
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wr_en_i,
    input  wire logic                      rd_en_i,
    input  wire logic [pol_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [W-1:0]              wdata_i,
    output logic      [W-1:0]              rdata_o,
    output logic                           rvalid_o,
    input  wire logic [W-1:0]              port_a_dir_out_i,
    input  wire logic [W-1:0]              port_b_dir_out_i,
    output logic      [W-1:0]              port_a_pin_do_o,
    output logic      [W-1:0]              port_a_pin_oe_o,
    output logic      [W-1:0]              port_a_pullup_en_o,
    output logic      [W-1:0]              port_b_pin_do_o,
    output logic      [W-1:0]              port_b_pin_oe_o,
    output logic      [W-1:0]              port_b_pullup_en_o,
    input  wire logic [W-1:0]              port_a_pin_i,
    output logic      [W-1:0]              port_a_pin_sync_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [W-1:0] port_a_output_latch_r;
    logic [W-1:0] port_b_output_latch_r;
    logic [W-1:0] pa_meta_r;
    logic [W-1:0] pa_sync_r;
    logic         hit_a;
    logic         hit_b;

    assign hit_a = (addr_i == pol_pkg::OFF_PORT_A);
    assign hit_b = (addr_i == pol_pkg::OFF_PORT_B);

    ////////////////////////////////////////////////////////////////////////////
    // latches change only on reset or a write; direction inputs never touch them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_a_output_latch_r <= W'(pol_pkg::LATCH_RESET);
            port_b_output_latch_r <= W'(pol_pkg::LATCH_RESET);
        end else if (wr_en_i) begin
            if (hit_a) begin
                port_a_output_latch_r <= wdata_i;
            end
            if (hit_b) begin
                port_b_output_latch_r <= wdata_i;
            end
        end
    end

    // read data registered one cycle after rd_en_i; unmapped reads zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o  <= '0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
            if (rd_en_i) begin
                if (hit_a) begin
                    rdata_o <= port_a_output_latch_r;
                end else if (hit_b) begin
                    rdata_o <= port_b_output_latch_r;
                end else begin
                    rdata_o <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port a pin levels synchronised for the external-interrupt logic
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pa_meta_r <= '0;
            pa_sync_r <= '0;
        end else begin
            pa_meta_r <= port_a_pin_i;
            pa_sync_r <= pa_meta_r;
        end
    end
    assign port_a_pin_sync_o = pa_sync_r;

    ////////////////////////////////////////////////////////////////////////////
    pol_pin_if #(.W(W)) pa_if ();
    pol_pin_if #(.W(W)) pb_if ();

    assign pa_if.latch   = port_a_output_latch_r;
    assign pa_if.dir_out = port_a_dir_out_i;
    assign pb_if.latch   = port_b_output_latch_r;
    assign pb_if.dir_out = port_b_dir_out_i;

    pol_pin_drv #(.W(W)) u_drv_a (
        .p (pa_if.drv)
    );
    pol_pin_drv #(.W(W)) u_drv_b (
        .p (pb_if.drv)
    );

    assign port_a_pin_do_o    = pa_if.pin_do;
    assign port_a_pin_oe_o    = pa_if.pin_oe;
    assign port_a_pullup_en_o = pa_if.pullup_en;
    assign port_b_pin_do_o    = pb_if.pin_do;
    assign port_b_pin_oe_o    = pb_if.pin_oe;
    assign port_b_pullup_en_o = pb_if.pullup_en;
endmodule
`default_nettype wire

/* File: tb/pol_port_latches_props.sv */
// checker: timing relations of the port output latches
`default_nettype none
module pol_port_latches_props (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wr_en_i,
    input wire logic       rd_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rvalid_o,
    input wire logic [7:0] port_a_dir_out_i,
    input wire logic [7:0] port_a_pin_do_o,
    input wire logic [7:0] port_a_pin_oe_o,
    input wire logic [7:0] port_a_pullup_en_o,
    input wire logic [7:0] port_b_pin_do_o,
    input wire logic [7:0] port_a_pin_i,
    input wire logic [7:0] port_a_pin_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_a; wr_en_i && addr_i == 4'h0; endsequence
    sequence wr_b; wr_en_i && addr_i == 4'h1; endsequence
    a_reset_ones: assert property ($fell(rst_i) |-> {port_a_pin_do_o, port_b_pin_do_o} == 16'hFFFF)
        else $error("latch not all ones after reset");
    a_write_a: assert property (wr_a |=> port_a_pin_do_o == $past(wdata_i))
        else $error("port a write lost");
    a_write_b: assert property (wr_b |=> port_b_pin_do_o == $past(wdata_i))
        else $error("port b write lost");
    a_read_latch: assert property (rd_en_i && addr_i == 4'h0 |=> rvalid_o && rdata_o == $past(port_a_pin_do_o))
        else $error("bad read data");
    a_dir_to_oe: assert property (port_a_pin_oe_o == port_a_dir_out_i)
        else $error("oe not from direction");
    a_pullup_role: assert property (port_a_pullup_en_o == (~port_a_dir_out_i & port_a_pin_do_o))
        else $error("bad pull-up");
    a_latch_holds: assert property (!wr_en_i |=> $stable(port_a_pin_do_o) && $stable(port_b_pin_do_o))
        else $error("latch moved");
    a_sync_two: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> port_a_pin_sync_o == $past(port_a_pin_i, 2))
        else $error("sync lag");
    a_rvalid_only: assert property (!$past(rd_en_i) |-> !rvalid_o)
        else $error("read valid without read");
    a_rdata_holds: assert property (!rd_en_i |=> $stable(rdata_o))
        else $error("read data moved");
endmodule
bind pol_port_latches pol_port_latches_props pol_port_latches_props_inst (.*);
`default_nettype wire

/* File: tb/pol_pin_load.sv */
// partner: circuitry on the port a pins
`default_nettype none
module pol_pin_load (
    input  wire logic       clk_i,
    input  wire logic [7:0] do_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_r = 8'h00;
    always_ff @(posedge clk_i) last_r <= pin_o;
    // undriven pins without pull-up toggle so no stale level passes
    assign pin_o = (oe_i & do_i)
                 | (~oe_i & ext_oe_i & ext_i)
                 | (~oe_i & ~ext_oe_i & (pu_i | ~last_r));
endmodule
`default_nettype wire

/* File: tb/tb_pol_port_latches.sv */
// testbench: register access and pin checks of the port latches
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %0t %h", $time, a); end end
module tb_pol_port_latches;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, we = 0, re = 0, rv;
    logic [3:0] ad = 4'h0;
    logic [7:0] wd = 8'h00, da = 8'h00, db = 8'h00, eo = 8'h00, ex = 8'h00, rdt, doa, oea, pua, dob, oeb, pub, pa, sy;
    int bad_count = 0, n_tests = 0, cyc = 0;
    pol_port_latches pol_port_latches_inst (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(we), .rd_en_i(re), .addr_i(ad),
        .wdata_i(wd), .rdata_o(rdt), .rvalid_o(rv), .port_a_dir_out_i(da), .port_b_dir_out_i(db),
        .port_a_pin_do_o(doa), .port_a_pin_oe_o(oea), .port_a_pullup_en_o(pua), .port_b_pin_do_o(dob),
        .port_b_pin_oe_o(oeb), .port_b_pullup_en_o(pub), .port_a_pin_i(pa), .port_a_pin_sync_o(sy));
    pol_pin_load pol_pin_load_inst (.clk_i(clk_i), .do_i(doa), .oe_i(oea), .pu_i(pua), .ext_oe_i(eo), .ext_i(ex),
        .pin_o(pa));
    always #2 clk_i = ~clk_i;
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i) {ad, wd, we} <= {a, d, 1'b1};
        @(posedge clk_i) we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i) {ad, re} <= {a, 1'b1};
        @(posedge clk_i) re <= 1'b0;
        #1 `CHK({rv, rdt}, {1'b1, e})
    endtask
    always @(posedge clk_i) if (++cyc == 2000) begin
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'hFF);
        rd(4'h1, 8'hFF);
        wr(4'h0, 8'h5A);
        wr(4'h1, 8'hA5);
        rd(4'h0, 8'h5A);
        rd(4'h1, 8'hA5);
        rd(4'h7, 8'h00);
        @(posedge clk_i) {da, db} <= 16'hF00F;
        #1 `CHK(pa & da, 8'h50)
        `CHK({pua, pub, dob & oeb}, 24'h0AA005)
        `CHK(pa & pua, 8'h0A)
        rd(4'h0, 8'h5A);
        rd(4'h1, 8'hA5);
        @(posedge clk_i) {da, eo, ex} <= 24'h00FF3C;
        repeat (3) @(posedge clk_i);
        #1 `CHK(sy, 8'h3C)
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        rd(4'h0, 8'hFF);
        @(posedge clk_i);
        #1 `CHK({rv, rdt}, 9'h0FF)
        give_verdict();
    end
endmodule
`default_nettype wire
